// File: src/eeprom_function_cmd.v
`timescale 1ns/1ps
`include "eeprom_function_code_defines.vh"

module eeprom_function_cmd #(
  parameter        HAS_UNIQUE_ID = 0,
  parameter [7:0]  FAMILY_CODE   = 8'h5a,          // arbitrary value
  parameter [47:0] SERIAL_FIELD  = 48'h0123456789ab, // arbitrary value
  parameter        PROG_CYCLES   = `PROGRAM_CYCLE_CYCLES
) (
  // clock and reset
  input  wire        clk,
  input  wire        rstn,
  input  wire        ce,
  // byte stream from serial engine (same clock)
  input  wire        wr_byte,
  input  wire        rd_byte,
  input  wire        first_byte,
  input  wire [7:0]  memory_pointer,
  input  wire [7:0]  wdata,
  input  wire        lock_enable,
  // answers to serial engine
  output reg  [7:0]  rdata_q,
  output wire        wr_accept,
  output wire        id_hit,
  // eeprom array control
  output reg         copy_busy_flag,
  output reg  [2:0]  copy_strobe_q,
  output reg  [2:0]  recall_strobe_q,
  output reg  [2:0]  lock_state_q,
  output reg  [1:0]  busy_block_q
);
  localparam ST_IDLE = 1'b0;
  localparam ST_PROG = 1'b1;

  reg        state_q;
  reg [31:0] cnt_q;
  reg        cmd_txn_q;    // current write transaction started at command loc
  reg        wr_start_q;   // start pointer of current write is in busy block
  reg        is_lock_q;
  wire [7:0] crc;
  wire [63:0] uid;
  wire [2:0]  present = (HAS_UNIQUE_ID != 0) ? 3'b011 : 3'b111;

  id_crc8 u_crc (
    .data (uid[55:0]),
    .crc  (crc)
  );
  assign uid = {crc, SERIAL_FIELD, FAMILY_CODE};

  function [1:0] blk_of;
    input [7:0] a;
    begin
      blk_of = a[5:4] - 2'd2;
    end
  endfunction

  wire in_blocks  = (memory_pointer >= `ADDR_BLK0_BASE) &&
                    (memory_pointer <  `ADDR_BLK2_BASE + `BLK_BYTES);
  wire [1:0] blk  = blk_of(memory_pointer);
  wire start_busy = copy_busy_flag && in_blocks && (blk == busy_block_q);
  wire id_range   = (HAS_UNIQUE_ID != 0) && (memory_pointer[7:3] == 5'h1e);
  wire busy_now   = first_byte ? start_busy : wr_start_q;
  assign id_hit   = id_range;
  // discard busy block locked blocks id bytes
  // command location itself; shadow-only writes go through
  assign wr_accept = wr_byte && !busy_now && !id_range &&
                     !(memory_pointer == `ADDR_FUNCTION_CMD) &&
                     !(in_blocks && (lock_state_q[blk] || !present[blk]));

  reg [2:0] cmd_blk;
  reg [1:0] cmd_kind;   // 1 copy, 2 recall, 3 lock, 0 none
  always @* begin
    cmd_blk  = 3'b000;
    cmd_kind = 2'd0;
    case (wdata)
      `FC_COPY0: begin
        cmd_blk  = 3'b001;
        cmd_kind = 2'd1;
      end
      `FC_COPY1: begin
        cmd_blk  = 3'b010;
        cmd_kind = 2'd1;
      end
      `FC_COPY2: begin
        cmd_blk  = 3'b100;
        cmd_kind = 2'd1;
      end
      `FC_RECALL0: begin
        cmd_blk  = 3'b001;
        cmd_kind = 2'd2;
      end
      `FC_RECALL1: begin
        cmd_blk  = 3'b010;
        cmd_kind = 2'd2;
      end
      `FC_RECALL2: begin
        cmd_blk  = 3'b100;
        cmd_kind = 2'd2;
      end
      `FC_LOCK0: begin
        cmd_blk  = 3'b001;
        cmd_kind = 2'd3;
      end
      `FC_LOCK1: begin
        cmd_blk  = 3'b010;
        cmd_kind = 2'd3;
      end
      `FC_LOCK2: begin
        cmd_blk  = 3'b100;
        cmd_kind = 2'd3;
      end
      default: begin
        cmd_blk  = 3'b000;
        cmd_kind = 2'd0;
      end
    endcase
  end

  wire [1:0] cmd_idx = cmd_blk[2] ? 2'd2 : (cmd_blk[1] ? 2'd1 : 2'd0);
  // only the first data byte of a transaction at the command location
  wire cmd_take  = wr_byte && first_byte && (memory_pointer == `ADDR_FUNCTION_CMD);
  wire blk_ok    = |(cmd_blk & present);
  // overlapping copy/lock while programming is dropped
  wire do_copy   = cmd_take && cmd_kind == 2'd1 && blk_ok && state_q == ST_IDLE &&
                   !(|(cmd_blk & lock_state_q));
  wire do_lock   = cmd_take && cmd_kind == 2'd3 && blk_ok && state_q == ST_IDLE &&
                   lock_enable;
  // recall into the block being programmed would race the copy, so drop it
  wire do_recall = cmd_take && cmd_kind == 2'd2 && blk_ok &&
                   !(copy_busy_flag && cmd_idx == busy_block_q);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q         <= ST_IDLE;
      cnt_q           <= 32'd0;
      copy_busy_flag  <= 1'b0;
      copy_strobe_q   <= 3'b000;
      recall_strobe_q <= 3'b000;
      lock_state_q    <= 3'b000;
      busy_block_q    <= 2'd0;
      is_lock_q       <= 1'b0;
      cmd_txn_q       <= 1'b0;
      wr_start_q      <= 1'b0;
      rdata_q         <= 8'h00;
    end else if (ce) begin
      copy_strobe_q   <= 3'b000;
      recall_strobe_q <= 3'b000;
      if (wr_byte && first_byte) begin
        cmd_txn_q  <= (memory_pointer == `ADDR_FUNCTION_CMD);
        wr_start_q <= start_busy;
      end
      if (do_recall) begin
        recall_strobe_q <= cmd_blk;
      end
      case (state_q)
        ST_IDLE: begin
          if (do_copy || do_lock) begin
            state_q        <= ST_PROG;
            cnt_q          <= PROG_CYCLES - 1;
            busy_block_q   <= cmd_idx;
            is_lock_q      <= do_lock;
            copy_busy_flag <= do_copy;
            if (do_copy) begin
              copy_strobe_q <= cmd_blk;
            end
          end
        end
        ST_PROG: begin
          if (cnt_q == 32'd0) begin
            state_q        <= ST_IDLE;
            copy_busy_flag <= 1'b0;
            if (is_lock_q) begin
              lock_state_q[busy_block_q] <= 1'b1;
            end
          end else begin
            cnt_q <= cnt_q - 32'd1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
      if (rd_byte) begin
        if (id_range) begin
          rdata_q <= uid[{memory_pointer[2:0], 3'b000} +: 8];
        end else begin
          rdata_q <= 8'hff; // every read outside the id bytes returns ff, command location included
        end
      end
    end
  end
endmodule

// File: src/eeprom_function_code_defines.vh
`ifndef EEPROM_FUNCTION_CODE_DEFINES_VH
`define EEPROM_FUNCTION_CODE_DEFINES_VH

// memory map
`define ADDR_FUNCTION_CMD    8'hfe
`define ADDR_UNIQUE_ID_BASE  8'hf0
`define ADDR_BLK0_BASE       8'h20
`define ADDR_BLK1_BASE       8'h30
`define ADDR_BLK2_BASE       8'h40
`define BLK_BYTES            16

// function codes
`define FC_COPY0    8'h42
`define FC_COPY1    8'h44
`define FC_COPY2    8'h48
`define FC_RECALL0  8'hb2
`define FC_RECALL1  8'hb4
`define FC_RECALL2  8'hb8
`define FC_LOCK0    8'h63
`define FC_LOCK1    8'h66
`define FC_LOCK2    8'h6a

// id layout
`define ID_FAMILY_LSB  0
`define ID_SERIAL_LSB  8
`define ID_CRC_LSB     56

// programming interval: 2 ms at 10 MHz
`define PROGRAM_CYCLE_TIME_US  2000
`define CLK_MHZ                10
`define PROGRAM_CYCLE_CYCLES   (`PROGRAM_CYCLE_TIME_US * `CLK_MHZ)

`endif

// File: src/id_crc8.v
`timescale 1ns/1ps
`include "eeprom_function_code_defines.vh"

// crc8 (poly x^8+x^5+x^4+1, lsb-first) over the low 56 id bits
module id_crc8 (
  // data in
  input  wire [55:0] data,
  // result
  output reg  [7:0]  crc
);
  integer i;
  reg     fb;
  always @* begin
    crc = 8'h00;
    fb  = 1'b0;
    for (i = 0; i < 56; i = i + 1) begin
      fb  = crc[0] ^ data[i];
      crc = {1'b0, crc[7:1]};
      if (fb) begin
        crc = crc ^ 8'h8c;
      end
    end
  end
endmodule

// File: test/function_code_asserts.sv
`timescale 1ns/1ps
module function_code_asserts #(parameter PROG_CYCLES = 10) (
  // watched ports
  input wire       clk, rstn, ce, wr_byte, first_byte, lock_enable,
  input wire       wr_accept, copy_busy_flag,
  input wire [7:0] memory_pointer, wdata,
  input wire [2:0] copy_strobe_q, lock_state_q, recall_strobe_q,
  input wire [1:0] busy_block_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  int cnt_q;
  always @(posedge clk or negedge rstn)
    if (!rstn) cnt_q <= 0;
    else if (ce) cnt_q <= copy_busy_flag ? cnt_q + 1 : 0;
  sequence s_cmd(c);
    ce && wr_byte && first_byte && memory_pointer == 8'hfe && wdata == c;
  endsequence
  sequence s_wr_busy;
    ce && wr_byte && first_byte && copy_busy_flag;
  endsequence
  a_copy_start: assert property (s_cmd(8'h42) ##0 !copy_busy_flag && !lock_state_q[0]
    |=> copy_busy_flag && copy_strobe_q == 3'b001) else $error("copy idle");
  a_busy_len: assert property ($fell(copy_busy_flag) |->
    cnt_q >= PROG_CYCLES && cnt_q <= PROG_CYCLES + 1) else $error("busy length");
  a_busy_block: assert property (s_wr_busy ##0
    memory_pointer[7:4] == {2'b00, busy_block_q} + 4'h2 |-> !wr_accept) else $error("busy write");
  a_write_outside: assert property (s_wr_busy ##0 busy_block_q != 2'd1
    && !lock_state_q[1] && memory_pointer[7:4] == 4'h3 |-> wr_accept) else $error("write lost");
  a_stray_cmd: assert property (ce && wr_byte && memory_pointer == 8'hfe
    && (!first_byte || wdata[7:4] == 4'h0) |=> copy_strobe_q == 3'b000
    && recall_strobe_q == 3'b000) else $error("stray command");
  a_locked_copy: assert property (s_cmd(8'h42) ##0 lock_state_q[0] |=>
    copy_strobe_q == 3'b000 && !$rose(copy_busy_flag)) else $error("locked copy");
  a_lock_sticky: assert property (1'b1 |=>
    (lock_state_q & $past(lock_state_q)) == $past(lock_state_q)) else $error("lock lost");
  a_lock_gate: assert property (s_cmd(8'h63) ##0 !lock_enable && !lock_state_q[0]
    |=> !lock_state_q[0] [*8]) else $error("lock gate");
endmodule
bind eeprom_function_cmd function_code_asserts #(.PROG_CYCLES(PROG_CYCLES)) chk_i (.*);

// File: test/byte_master.sv
`timescale 1ns/1ps
module byte_master (
  input wire         clk,
  output logic       wr_byte, rd_byte, first_byte,
  output logic [7:0] memory_pointer, wdata
);
  initial {wr_byte, rd_byte, first_byte, memory_pointer, wdata} = 0;
  task xfer(input logic w, f, input logic [7:0] p, d);
    @(posedge clk) #1;
    {wr_byte, rd_byte, first_byte, memory_pointer, wdata} = {w, !w, f, p, d};
    @(posedge clk) #1;
    // released pointer and data lines show the inverse; first_byte keeps its last value
    {wr_byte, rd_byte, memory_pointer, wdata} = {2'b00, ~p, ~d};
  endtask
endmodule

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
  localparam logic [55:0] uid = 56'h1f2e3d4c5b6a3c;
  logic       clk = 0, rstn = 0, ce = 1, lock_enable = 0, rd_seen = 0;
  logic       wr_byte, rd_byte, first_byte, wr_accept, id_hit, copy_busy_flag;
  logic [7:0] memory_pointer, wdata, rdata_q, exp_q[$];
  logic       acc_q[$];
  logic [7:0] lk[3] = '{8'h63, 8'h66, 8'h6a};
  logic [2:0] copy_strobe_q, recall_strobe_q, lock_state_q;
  logic [1:0] busy_block_q;
  int         error_cnt = 0, tests_run = 0, cyc = 0;
  always #50 clk = ~clk;
  eeprom_function_cmd #(.HAS_UNIQUE_ID(1), .FAMILY_CODE(uid[7:0]),
    .SERIAL_FIELD(uid[55:8]), .PROG_CYCLES(16)) dut (.*);
  byte_master m (.*);
  function automatic logic [7:0] crc8(input logic [55:0] v);
    logic [7:0] c = 8'h00;
    for (int i = 0; i < 56; i++)
      c = (c >> 1) ^ ((c[0] ^ v[i]) ? 8'h8c : 8'h00);
    return c;
  endfunction
  task wr(input logic f, input logic [7:0] p, d, input logic a);
    acc_q.push_back(a);
    m.xfer(1, f, p, d);
  endtask
  task rd(input logic f, input logic [7:0] p, e, input logic h);
    exp_q.push_back(e);
    acc_q.push_back(h);
    m.xfer(0, f, p, 8'h00);
  endtask
  task chk(input logic [7:0] got, e);
    tests_run++;
    if (got !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, e);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rd_seen) chk(rdata_q, exp_q.pop_front());
    if (wr_byte || rd_byte) chk(wr_byte ? wr_accept : id_hit, acc_q.pop_front());
    rd_seen <= rd_byte;
    if (++cyc == 2000) begin
      error_cnt++;
      conclude();
    end
  end
  task cmd(input logic [7:0] c, input logic [2:0] cs, rs, input logic b);
    wr(1, 8'hfe, c, 0);
    chk(copy_strobe_q, cs);
    chk(recall_strobe_q, rs);
    chk(copy_busy_flag, b);
  endtask
  task idle;
    // longer than one programming interval
    repeat (18) @(posedge clk);
    #1 chk(copy_busy_flag, 0);
  endtask
  initial begin
    void'($urandom(86014));
    repeat (3) @(posedge clk);
    #1 rstn = 1;
    for (int i = 0; i < 8; i++)
      rd(i == 0, 8'(8'hf0 + i), i < 7 ? uid[8*i +: 8] : crc8(uid), 1);
    rd(1, 8'hf8, 8'hff, 0);
    wr(1, 8'hf0, 8'h00, 0);
    rd(1, 8'hf0, uid[7:0], 1);
    $display("id test done");
    cmd(8'h42, 3'b001, 0, 1);
    cmd(8'hb2, 0, 0, 1);
    wr(1, 8'h20, 8'($urandom), 0);
    wr(1, 8'h30, 8'($urandom), 1);
    rd(1, 8'hf0, uid[7:0], 1);
    cmd(8'h44, 0, 0, 1);
    idle();
    cmd(8'h44, 3'b010, 0, 1);
    chk(busy_block_q, 8'h01);
    idle();
    cmd(8'h48, 0, 0, 0);
    for (int k = 0; k < 3; k++)
      cmd(8'hb0 | (8'h02 << k), 0, k < 2 ? 3'b001 << k : 3'b000, 0);
    repeat (4) cmd({4'h0, 4'($urandom)}, 0, 0, 0);
    wr(0, 8'hfe, 8'h42, 0);
    chk(copy_busy_flag, 0);
    $display("command test done");
    cmd(8'h63, 0, 0, 0);
    idle();
    chk(lock_state_q, 0);
    lock_enable = 1;
    for (int k = 0; k < 3; k++) begin
      cmd(lk[k], 0, 0, 0);
      idle();
    end
    chk(lock_state_q, 3'b011);
    cmd(8'h42, 0, 0, 0);
    $display("lock test done");
    conclude();
  end
endmodule
